// ===== src/dcf_pkg.sv
// dcf_pkg: address map, field layout and decode constants of the configuration words.
// assumes the core presents 24-bit table addresses and byte-wide table data.
package dcf_pkg;

    localparam int ADDR_W = 24;
    localparam int NUM_WORDS = 9;

    // table address map
    localparam logic [23:0] CFG_BASE = 24'hF80000;
    localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] CFG_SPACE_HI = 24'hFFFFFF;
    localparam logic [23:0] OFS_BOOT_SEGMENT = 24'hF80000;
    localparam logic [23:0] OFS_RESERVED = 24'hF80002;
    localparam logic [23:0] OFS_GENERAL_SEGMENT = 24'hF80004;
    localparam logic [23:0] OFS_OSC_SELECT = 24'hF80006;
    localparam logic [23:0] OFS_OSCILLATOR = 24'hF80008;
    localparam logic [23:0] OFS_WATCHDOG = 24'hF8000A;
    localparam logic [23:0] OFS_POWER_ON = 24'hF8000C;
    localparam logic [23:0] OFS_DEBUG = 24'hF8000E;
    localparam logic [23:0] OFS_COMPARATOR = 24'hF80010;

    // implemented-bit masks, word index order
    localparam logic [7:0] MASK_BOOT_SEGMENT = 8'h0F;
    localparam logic [7:0] MASK_RESERVED = 8'h00;
    localparam logic [7:0] MASK_GENERAL_SEGMENT = 8'h07;
    localparam logic [7:0] MASK_OSC_SELECT = 8'h87;
    localparam logic [7:0] MASK_OSCILLATOR = 8'hC7;
    localparam logic [7:0] MASK_WATCHDOG = 8'hDF;
    localparam logic [7:0] MASK_POWER_ON = 8'h67;
    localparam logic [7:0] MASK_DEBUG = 8'hE3;
    localparam logic [7:0] MASK_COMPARATOR = 8'h3F;

    // erased state: unprogrammed bits read one
    localparam logic [7:0] ERASED_WORD = 8'hFF;

    // field positions
    localparam int POS_BOOT_WP = 0;
    localparam int POS_BOOT_SIZE = 1;
    localparam int POS_GEN_WP = 0;
    localparam int POS_GEN_CP = 1;
    localparam int POS_OSC_SRC = 0;
    localparam int POS_TWO_SPEED = 7;
    localparam int POS_PRI_MODE = 0;
    localparam int POS_SECOND_OSCILLATOR_PIN_FN = 2;
    localparam int POS_CLK_MON = 6;
    localparam int POS_WD_POST = 0;
    localparam int POS_WD_PRE = 4;
    localparam int POS_WD_WIN = 6;
    localparam int POS_WD_FORCE = 7;
    localparam int POS_PWRT = 0;
    localparam int POS_ALT_SS = 5;
    localparam int POS_ALT_QEI = 6;
    localparam int POS_DBG_CH = 0;
    localparam int POS_JTAG = 5;
    localparam int POS_HYS_EVEN = 0;
    localparam int POS_POL_EVEN = 2;
    localparam int POS_HYS_ODD = 3;
    localparam int POS_POL_ODD = 5;

    // boot segment end addresses
    localparam logic [23:0] BOOT_END_SMALL = 24'h0003FE;
    localparam logic [23:0] BOOT_END_MID = 24'h0007FE;
    localparam logic [23:0] BOOT_END_LARGE = 24'h000FFE;

    // power-on timer: 2 ms at code 001, doubling per code
    localparam int PWRT_BASE_MS = 2;
    localparam int CLK_MHZ = 250;
    localparam int PWRT_BASE_CYCLES = PWRT_BASE_MS * 1000 * CLK_MHZ;

    // watchdog prescale ratios
    localparam logic [7:0] WD_PRE_LONG = 8'h80;
    localparam logic [7:0] WD_PRE_SHORT = 8'h20;

    typedef enum logic [2:0] {
        DCF_SEC_NONE = 3'b001,
        DCF_SEC_STANDARD = 3'b010,
        DCF_SEC_HIGH = 3'b100
    } dcf_security_e;

    typedef enum logic [7:0] {
        DCF_OSC_FRC = 8'h01,
        DCF_OSC_FRC_PLL = 8'h02,
        DCF_OSC_PRI = 8'h04,
        DCF_OSC_PRI_PLL = 8'h08,
        DCF_OSC_SEC = 8'h10,
        DCF_OSC_LOW_POWER_RC_OSCILLATOR = 8'h20,
        DCF_OSC_FRC_DIV16 = 8'h40,
        DCF_OSC_FRC_POST = 8'h80
    } dcf_osc_e;

    typedef enum logic [3:0] {
        DCF_PRI_EC = 4'h1,
        DCF_PRI_XT = 4'h2,
        DCF_PRI_HS = 4'h4,
        DCF_PRI_OFF = 4'h8
    } dcf_pri_e;

    // table access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [23:0] addr;
        logic [7:0] wdata;
    } dcf_table_req_s;

    // decoded fields for the consuming logic
    typedef struct packed {
        logic boot_write_allow;
        logic [23:0] boot_segment_end;
        logic boot_segment_present;
        dcf_security_e boot_security;
        dcf_security_e general_security;
        logic general_write_allow;
        logic two_speed_startup;
        dcf_osc_e osc_source;
        logic clock_switch_enable;
        logic fail_safe_enable;
        logic second_oscillator_pin_clock_out;
        dcf_pri_e primary_osc_mode;
        logic watchdog_forced;
        logic watchdog_window_mode;
        logic [7:0] watchdog_prescale_ratio;
        logic [15:0] watchdog_postscale_ratio;
        logic power_on_timer_enable;
        logic [31:0] power_on_timer_cycles;
        logic boundary_scan_enable;
        logic [2:0] debug_pair_onehot;
        logic alt_encoder_pins;
        logic alt_slave_select_pin;
        logic even_hyst_falling;
        logic [1:0] even_hyst_level;
        logic odd_hyst_falling;
        logic [1:0] odd_hyst_level;
    } dcf_fields_s;

endpackage : dcf_pkg

// ===== src/dcf_config_words.sv
// dcf_config_words: nine write-once configuration bytes behind table reads/writes,
// plus decode of every field for the clock, watchdog, protection and pin logic.
// assumes rst_n is the power-on reset; other device resets arrive on dev_reset_pulse.
`timescale 1ns/100ps

module dcf_config_words (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dev_reset_pulse,
    input wire dcf_pkg::dcf_table_req_s table_req,
    input wire logic software_watchdog_enable,
    output logic [7:0] table_rdata,
    output logic table_hit,
    output logic write_ignored,
    output dcf_pkg::dcf_fields_s fields,
    output logic watchdog_run,
    output logic low_power_rc_force_on
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // word index for a table address, NUM_WORDS when unmapped
    function automatic logic [3:0] word_index(input logic [23:0] addr);
        logic [23:0] ofs;
        ofs = addr - dcf_pkg::CFG_BASE;
        if (addr >= dcf_pkg::CFG_BASE && ofs[0] == 1'b0 && ofs < 24'h000012) begin
            word_index = ofs[4:1];
        end else begin
            word_index = 4'(dcf_pkg::NUM_WORDS);
        end
    endfunction : word_index

    // implemented bits of each word
    function automatic logic [7:0] word_mask(input logic [3:0] idx);
        unique case (idx)
            4'h0: word_mask = dcf_pkg::MASK_BOOT_SEGMENT;
            4'h1: word_mask = dcf_pkg::MASK_RESERVED;
            4'h2: word_mask = dcf_pkg::MASK_GENERAL_SEGMENT;
            4'h3: word_mask = dcf_pkg::MASK_OSC_SELECT;
            4'h4: word_mask = dcf_pkg::MASK_OSCILLATOR;
            4'h5: word_mask = dcf_pkg::MASK_WATCHDOG;
            4'h6: word_mask = dcf_pkg::MASK_POWER_ON;
            4'h7: word_mask = dcf_pkg::MASK_DEBUG;
            4'h8: word_mask = dcf_pkg::MASK_COMPARATOR;
            default: word_mask = 8'h00;
        endcase
    endfunction : word_mask

    // three-state security code, used by boot and general segments
    function automatic dcf_pkg::dcf_security_e sec_code(input logic none, input logic std);
        if (none) begin
            sec_code = dcf_pkg::DCF_SEC_NONE;
        end else if (std) begin
            sec_code = dcf_pkg::DCF_SEC_STANDARD;
        end else begin
            sec_code = dcf_pkg::DCF_SEC_HIGH;
        end
    endfunction : sec_code

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile array and write-once tracking

    logic [7:0] nv_word [dcf_pkg::NUM_WORDS];
    logic [7:0] written [dcf_pkg::NUM_WORDS];
    logic [3:0] req_idx;
    logic req_mapped;

    assign req_idx = word_index(table_req.addr);
    assign req_mapped = (req_idx != 4'(dcf_pkg::NUM_WORDS));

    // one write per word per power cycle
    // the written mask only clears with rst_n, which stands for power removal;
    // a program of zero clears a bit, a one leaves it erased
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dcf_pkg::NUM_WORDS; i++) begin
                nv_word[i] <= dcf_pkg::ERASED_WORD;
                written[i] <= 8'h00;
            end
        end else if (table_req.wr && req_mapped) begin
            for (int i = 0; i < dcf_pkg::NUM_WORDS; i++) begin
                if (4'(i) == req_idx) begin
                    nv_word[i] <= nv_word[i] & (table_req.wdata | written[i]
                                  | ~word_mask(req_idx));
                    written[i] <= written[i] | word_mask(req_idx);
                end
            end
        end
    end

    // read data and write status; all outputs registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            table_rdata <= 8'h00;
            table_hit <= 1'b0;
            write_ignored <= 1'b0;
        end else begin
            table_hit <= (table_req.rd || table_req.wr) && req_mapped;
            write_ignored <= table_req.wr && req_mapped
                             && ((written[req_idx] & word_mask(req_idx)) != 8'h00);
            if (table_req.rd && req_mapped) begin
                table_rdata <= nv_word[req_idx] & word_mask(req_idx);
            end else begin
                table_rdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field decode

    logic [7:0] w_boot;
    logic [7:0] w_gen;
    logic [7:0] w_osel;
    logic [7:0] w_osc;
    logic [7:0] w_wdt;
    logic [7:0] w_por;
    logic [7:0] w_dbg;
    logic [7:0] w_cmp;
    dcf_pkg::dcf_fields_s next_fields;
    logic [2:0] boot_size;
    logic [2:0] osc_code;
    logic [2:0] pwrt;
    logic [1:0] pri;
    logic [1:0] dbg_ch;

    assign w_boot = nv_word[0];
    assign w_gen = nv_word[2];
    assign w_osel = nv_word[3];
    assign w_osc = nv_word[4];
    assign w_wdt = nv_word[5];
    assign w_por = nv_word[6];
    assign w_dbg = nv_word[7];
    assign w_cmp = nv_word[8];
    assign boot_size = w_boot[dcf_pkg::POS_BOOT_SIZE +: 3];
    assign osc_code = w_osel[dcf_pkg::POS_OSC_SRC +: 3];
    assign pwrt = w_por[dcf_pkg::POS_PWRT +: 3];
    assign pri = w_osc[dcf_pkg::POS_PRI_MODE +: 2];
    assign dbg_ch = w_dbg[dcf_pkg::POS_DBG_CH +: 2];

    // combinational decode of the live array
    always_comb begin
        next_fields = '0;
        next_fields.boot_write_allow = w_boot[dcf_pkg::POS_BOOT_WP];
        next_fields.boot_segment_present = (boot_size[1:0] != 2'b11);
        next_fields.boot_security = sec_code(boot_size[1:0] == 2'b11, boot_size[2]);
        unique case (boot_size[1:0])
            2'b10: next_fields.boot_segment_end = dcf_pkg::BOOT_END_SMALL;
            2'b01: next_fields.boot_segment_end = dcf_pkg::BOOT_END_MID;
            2'b00: next_fields.boot_segment_end = dcf_pkg::BOOT_END_LARGE;
            2'b11: next_fields.boot_segment_end = 24'h000000;
        endcase
        next_fields.general_security = sec_code(w_gen[2:1] == 2'b11, w_gen[2:1] == 2'b10);
        next_fields.general_write_allow = w_gen[dcf_pkg::POS_GEN_WP];
        next_fields.two_speed_startup = w_osel[dcf_pkg::POS_TWO_SPEED];
        next_fields.osc_source = dcf_pkg::dcf_osc_e'(8'h01 << osc_code);
        next_fields.clock_switch_enable = ~w_osc[dcf_pkg::POS_CLK_MON + 1];
        next_fields.fail_safe_enable = (w_osc[dcf_pkg::POS_CLK_MON +: 2] == 2'b00);
        next_fields.primary_osc_mode = dcf_pkg::dcf_pri_e'(4'h1 << pri);
        // second_oscillator_pin clock out, not in crystal modes
        next_fields.second_oscillator_pin_clock_out = w_osc[dcf_pkg::POS_SECOND_OSCILLATOR_PIN_FN]
                                     && (pri != 2'b01) && (pri != 2'b10);
        next_fields.watchdog_forced = w_wdt[dcf_pkg::POS_WD_FORCE];
        next_fields.watchdog_window_mode = ~w_wdt[dcf_pkg::POS_WD_WIN];
        next_fields.watchdog_prescale_ratio = w_wdt[dcf_pkg::POS_WD_PRE]
                                              ? dcf_pkg::WD_PRE_LONG : dcf_pkg::WD_PRE_SHORT;
        next_fields.watchdog_postscale_ratio = 16'h0001 << w_wdt[dcf_pkg::POS_WD_POST +: 4];
        next_fields.power_on_timer_enable = (pwrt != 3'b000);
        next_fields.power_on_timer_cycles = (pwrt == 3'b000) ? 32'h00000000
            : 32'(dcf_pkg::PWRT_BASE_CYCLES) << (pwrt - 3'b001);
        // boundary scan and debug pair; 00 selects none
        next_fields.boundary_scan_enable = w_dbg[dcf_pkg::POS_JTAG];
        unique case (dbg_ch)
            2'b11: next_fields.debug_pair_onehot = 3'b001;
            2'b10: next_fields.debug_pair_onehot = 3'b010;
            2'b01: next_fields.debug_pair_onehot = 3'b100;
            2'b00: next_fields.debug_pair_onehot = 3'b000;
        endcase
        next_fields.alt_encoder_pins = ~w_por[dcf_pkg::POS_ALT_QEI];
        next_fields.alt_slave_select_pin = w_por[dcf_pkg::POS_ALT_SS];
        next_fields.even_hyst_falling = w_cmp[dcf_pkg::POS_POL_EVEN];
        next_fields.even_hyst_level = w_cmp[dcf_pkg::POS_HYS_EVEN +: 2];
        next_fields.odd_hyst_falling = w_cmp[dcf_pkg::POS_POL_ODD];
        next_fields.odd_hyst_level = w_cmp[dcf_pkg::POS_HYS_ODD +: 2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // working registers

    // clear to zero at reset, then track
    // most fields take effect at once; the oscillator source moves only on a
    // device reset while switching is enabled; with switching disabled it follows the array at once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fields <= '0;
        end else begin
            fields <= next_fields;
            if (next_fields.clock_switch_enable && !dev_reset_pulse) begin
                fields.osc_source <= fields.osc_source;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_run <= 1'b0;
            low_power_rc_force_on <= 1'b0;
        end else begin
            watchdog_run <= next_fields.watchdog_forced || software_watchdog_enable;
            low_power_rc_force_on <= next_fields.watchdog_forced;
        end
    end

endmodule : dcf_config_words

// ===== testbench/dcf_config_monitor.sv
// dcf_config_monitor: port-level checks of the configuration word block.
// assumes one clock domain and the async active-low power-on reset.
`timescale 1ns/100ps
module dcf_config_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dev_reset_pulse,
    input wire dcf_pkg::dcf_table_req_s table_req,
    input wire logic software_watchdog_enable,
    input wire logic [7:0] table_rdata,
    input wire logic table_hit,
    input wire logic write_ignored,
    input wire dcf_pkg::dcf_fields_s fields,
    input wire logic watchdog_run,
    input wire logic low_power_rc_force_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    localparam logic [71:0] MASKS = {dcf_pkg::MASK_COMPARATOR, dcf_pkg::MASK_DEBUG,
        dcf_pkg::MASK_POWER_ON, dcf_pkg::MASK_WATCHDOG, dcf_pkg::MASK_OSCILLATOR,
        dcf_pkg::MASK_OSC_SELECT, dcf_pkg::MASK_GENERAL_SEGMENT, dcf_pkg::MASK_RESERVED,
        dcf_pkg::MASK_BOOT_SEGMENT};
    logic map;
    logic acc;
    logic [3:0] idx;
    logic [7:0] msk;
    logic [8:0] written;
    ////////////////////////////////////////////////////////////////////////////////////
    // address decode kept apart from the design so a shared slip cannot hide
    assign map = table_req.addr >= dcf_pkg::CFG_BASE
        && table_req.addr <= dcf_pkg::OFS_COMPARATOR && !table_req.addr[0];
    assign acc = table_req.rd || table_req.wr;
    assign idx = table_req.addr[4:1];
    assign msk = MASKS[int'(idx) * 8 +: 8];
    // words written this power cycle, the reserved word too; the write checks below leave it out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            written <= 9'h000;
        end else if (table_req.wr && map) begin
            written[idx] <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    a_hit_on_map: assert property (acc && map |=> table_hit)
        else $error("mapped access gave no hit");
    a_no_hit_off: assert property (!(acc && map) |=> !table_hit && !write_ignored)
        else $error("hit without a mapped access");
    a_rdata_idle: assert property (!(table_req.rd && map) |=> table_rdata == 8'h00)
        else $error("read data without a mapped read");
    a_unimpl_zero: assert property (
        table_req.rd && map |=> (table_rdata & ~$past(msk)) == 8'h00)
        else $error("unimplemented bit read as one");
    a_first_write: assert property (
        table_req.wr && map && idx != 4'h1 && !written[idx] |=> !write_ignored)
        else $error("first write reported ignored");
    a_repeat_ignored: assert property (
        table_req.wr && map && idx != 4'h1 && written[idx] |=> write_ignored)
        else $error("second write not ignored");
    // fields trail the array by one edge, so the write that moves them is one cycle earlier
    a_fields_hold: assert property (
        !(table_req.wr && map) ##1 !dev_reset_pulse |=> $stable(fields))
        else $error("fields moved without a write");
    a_boot_decode: assert property (
        table_req.rd && table_req.addr == dcf_pkg::OFS_BOOT_SEGMENT |=>
        fields.boot_write_allow == table_rdata[0]
        && fields.boot_segment_present == !(&table_rdata[2:1]))
        else $error("boot fields disagree with stored word");
    a_wdog_decode: assert property (
        table_req.rd && table_req.addr == dcf_pkg::OFS_WATCHDOG |=>
        fields.watchdog_prescale_ratio == (table_rdata[4] ? 8'h80 : 8'h20)
        && fields.watchdog_postscale_ratio == (16'h0001 << table_rdata[3:0]))
        else $error("watchdog scale fields disagree with stored word");
    a_forced_run: assert property (
        fields.watchdog_forced ##1 fields.watchdog_forced |->
        low_power_rc_force_on && watchdog_run)
        else $error("forced watchdog not running");
    c_write_hit: cover property (table_req.wr && map ##1 table_hit);
    c_ignored: cover property (write_ignored);
    c_dev_reset: cover property (dev_reset_pulse);
    c_sw_run: cover property (software_watchdog_enable && !fields.watchdog_forced);
endmodule : dcf_config_monitor

bind dcf_config_words dcf_config_monitor dcf_config_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .dev_reset_pulse(dev_reset_pulse),
    .table_req(table_req), .software_watchdog_enable(software_watchdog_enable),
    .table_rdata(table_rdata), .table_hit(table_hit), .write_ignored(write_ignored),
    .fields(fields), .watchdog_run(watchdog_run),
    .low_power_rc_force_on(low_power_rc_force_on)
);

// ===== testbench/dcf_core_model.sv
// dcf_core_model: processor core side, issuing table reads and writes.
// assumes requests start at a falling edge and are taken at the next rising edge.
`timescale 1ns/100ps
module dcf_core_model (
    input wire logic clk_sys,
    input wire logic [7:0] table_rdata,
    input wire logic table_hit,
    input wire logic write_ignored,
    output dcf_pkg::dcf_table_req_s table_req
);
    initial table_req = '{rd: 1'b0, wr: 1'b0, addr: 24'h000000, wdata: 8'h00};
    task automatic access(input logic rd, input logic wr, input logic [23:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic h, output logic ig);
        @(negedge clk_sys);
        table_req = '{rd: rd, wr: wr, addr: a, wdata: d};
        @(negedge clk_sys);
        q = table_rdata;
        h = table_hit;
        ig = write_ignored;
        // idle bus shows inverted values so stale data never looks like a request
        table_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : dcf_core_model

// ===== testbench/testbench.sv
// testbench: table accesses against the configuration words, checked at the ports.
// assumes the core model drives every request at a falling edge.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic dev_reset_pulse = 1'b0;
    logic software_watchdog_enable = 1'b0;
    dcf_pkg::dcf_table_req_s table_req;
    logic [7:0] table_rdata;
    logic table_hit;
    logic write_ignored;
    dcf_pkg::dcf_fields_s fields;
    logic watchdog_run;
    logic low_power_rc_force_on;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] q;
    logic h;
    logic ig;
    // erased image of the nine words, word 0 in the low byte
    localparam logic [71:0] ERASED = 72'h3FE367DFC78707000F;
    ////////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;
    dcf_config_words dcf_config_words_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .dev_reset_pulse(dev_reset_pulse), .table_req(table_req),
        .software_watchdog_enable(software_watchdog_enable), .table_rdata(table_rdata),
        .table_hit(table_hit), .write_ignored(write_ignored), .fields(fields),
        .watchdog_run(watchdog_run), .low_power_rc_force_on(low_power_rc_force_on));
    dcf_core_model dcf_core_model_i (.clk_sys(clk_sys), .table_rdata(table_rdata),
        .table_hit(table_hit), .write_ignored(write_ignored), .table_req(table_req));
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic rd_chk(input logic [23:0] a, input logic [7:0] e, input logic eh);
        dcf_core_model_i.access(1'b1, 1'b0, a, 8'h00, q, h, ig);
        `CHK(q, e)
        `CHK(h, eh)
    endtask : rd_chk
    task automatic wr_chk(input logic [23:0] a, input logic [7:0] d, input logic eig);
        dcf_core_model_i.access(1'b0, 1'b1, a, d, q, h, ig);
        `CHK(h, 1'b1)
        `CHK(ig, eig)
        // decoded fields register one edge after the array changes
        @(negedge clk_sys);
    endtask : wr_chk
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog: the whole run needs well under 200 cycles
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd_chk(dcf_pkg::CFG_BASE + 24'(2 * i), ERASED[i * 8 +: 8], 1'b1);
        end
        rd_chk(24'hF80001, 8'h00, 1'b0);
        rd_chk(24'hF80012, 8'h00, 1'b0);
        rd_chk(24'h780000, 8'h00, 1'b0);
        `CHK(fields.boot_segment_present, 1'b0)
        `CHK(fields.general_security, dcf_pkg::DCF_SEC_NONE)
        `CHK(fields.osc_source, dcf_pkg::DCF_OSC_FRC_POST)
        `CHK(fields.two_speed_startup, 1'b1)
        `CHK(fields.primary_osc_mode, dcf_pkg::DCF_PRI_OFF)
        `CHK(fields.second_oscillator_pin_clock_out, 1'b1)
        `CHK(fields.power_on_timer_enable, 1'b1)
        `CHK(fields.watchdog_postscale_ratio, 16'h8000)
        `CHK(fields.power_on_timer_cycles, 32'h01E84800)
        `CHK(fields.even_hyst_level, 2'h3)
        `CHK(watchdog_run, 1'b1)
        `CHK(low_power_rc_force_on, 1'b1)
        wr_chk(dcf_pkg::OFS_BOOT_SEGMENT, 8'hFC, 1'b0);
        `CHK(fields.boot_write_allow, 1'b0)
        `CHK(fields.boot_segment_end, dcf_pkg::BOOT_END_SMALL)
        `CHK(fields.boot_security, dcf_pkg::DCF_SEC_STANDARD)
        wr_chk(dcf_pkg::OFS_BOOT_SEGMENT, 8'h00, 1'b1);
        rd_chk(dcf_pkg::OFS_BOOT_SEGMENT, 8'h0C, 1'b1);
        wr_chk(dcf_pkg::OFS_GENERAL_SEGMENT, 8'hFD, 1'b0);
        `CHK(fields.general_security, dcf_pkg::DCF_SEC_STANDARD)
        `CHK(fields.general_write_allow, 1'b1)
        wr_chk(dcf_pkg::OFS_OSCILLATOR, 8'h7E, 1'b0);
        `CHK(fields.clock_switch_enable, 1'b1)
        `CHK(fields.fail_safe_enable, 1'b0)
        `CHK(fields.primary_osc_mode, dcf_pkg::DCF_PRI_HS)
        `CHK(fields.second_oscillator_pin_clock_out, 1'b0)
        wr_chk(dcf_pkg::OFS_OSC_SELECT, 8'h02, 1'b0);
        `CHK(fields.osc_source, dcf_pkg::DCF_OSC_FRC_POST)
        `CHK(fields.two_speed_startup, 1'b0)
        @(negedge clk_sys);
        dev_reset_pulse = 1'b1;
        @(negedge clk_sys);
        dev_reset_pulse = 1'b0;
        @(negedge clk_sys);
        `CHK(fields.osc_source, dcf_pkg::DCF_OSC_PRI)
        wr_chk(dcf_pkg::OFS_WATCHDOG, 8'h05, 1'b0);
        rd_chk(dcf_pkg::OFS_WATCHDOG, 8'h05, 1'b1);
        `CHK(fields.watchdog_window_mode, 1'b1)
        `CHK(fields.watchdog_prescale_ratio, dcf_pkg::WD_PRE_SHORT)
        `CHK(fields.watchdog_postscale_ratio, 16'h0020)
        `CHK(low_power_rc_force_on, 1'b0)
        `CHK(watchdog_run, 1'b0)
        software_watchdog_enable = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(watchdog_run, 1'b1)
        wr_chk(dcf_pkg::OFS_POWER_ON, 8'hA1, 1'b0);
        `CHK(fields.power_on_timer_cycles, 32'h0007A120)
        `CHK(fields.alt_slave_select_pin, 1'b1)
        `CHK(fields.alt_encoder_pins, 1'b1)
        wr_chk(dcf_pkg::OFS_DEBUG, 8'hC2, 1'b0);
        rd_chk(dcf_pkg::OFS_DEBUG, 8'hC2, 1'b1);
        `CHK(fields.boundary_scan_enable, 1'b0)
        `CHK(fields.debug_pair_onehot, 3'h2)
        wr_chk(dcf_pkg::OFS_COMPARATOR, 8'h2D, 1'b0);
        `CHK(fields.odd_hyst_falling, 1'b1)
        `CHK(fields.odd_hyst_level, 2'h1)
        `CHK(fields.even_hyst_falling, 1'b1)
        `CHK(fields.even_hyst_level, 2'h1)
        wr_chk(dcf_pkg::OFS_RESERVED, 8'h00, 1'b0);
        rd_chk(dcf_pkg::OFS_RESERVED, 8'h00, 1'b1);
        // power cycle: write-once marks clear and the array erases again
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_chk(dcf_pkg::OFS_BOOT_SEGMENT, 8'h0F, 1'b1);
        wr_chk(dcf_pkg::OFS_BOOT_SEGMENT, 8'h00, 1'b0);
        `CHK(fields.boot_segment_end, dcf_pkg::BOOT_END_LARGE)
        `CHK(fields.boot_security, dcf_pkg::DCF_SEC_HIGH)
        wr_chk(dcf_pkg::OFS_GENERAL_SEGMENT, 8'h00, 1'b0);
        `CHK(fields.general_security, dcf_pkg::DCF_SEC_HIGH)
        `CHK(fields.general_write_allow, 1'b0)
        // switching is off after erase, so the source follows at once
        wr_chk(dcf_pkg::OFS_OSC_SELECT, 8'h05, 1'b0);
        `CHK(fields.osc_source, dcf_pkg::DCF_OSC_LOW_POWER_RC_OSCILLATOR)
        tally_and_finish();
    end
endmodule : testbench
